// ==== timer_two_pkg.sv ====
// Constants, register map and mode encoding for the reload/capture timer.
// Assumes a byte-wide register port and a single 50 MHz system clock.
package timer_two_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam int ADDR_WIDTH = 3;
  localparam logic [2:0] REG_CONTROL = 3'h0;
  localparam logic [2:0] REG_MODE = 3'h1;
  localparam logic [2:0] REG_PRESCALE = 3'h2;
  localparam logic [2:0] REG_IRQ_ENABLE = 3'h3;
  localparam logic [2:0] REG_COUNT_LOW = 3'h4;
  localparam logic [2:0] REG_COUNT_HIGH = 3'h5;
  localparam logic [2:0] REG_RELOAD_LOW = 3'h6;
  localparam logic [2:0] REG_RELOAD_HIGH = 3'h7;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_OVERFLOW = 7;
  localparam int BIT_EXT_EVENT = 6;
  localparam int BIT_RX_BAUD = 5;
  localparam int BIT_TX_BAUD = 4;
  localparam int BIT_EXT_ENABLE = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_COUNTER_SEL = 1;
  localparam int BIT_CAPTURE_SEL = 0;
  localparam int BIT_CLOCK_OUT = 1;
  localparam int BIT_DOWN_COUNT = 0;
  localparam int BIT_PRESCALE_BYPASS = 0;
  localparam int BIT_GLOBAL_IRQ = 1;
  localparam int BIT_TIMER_IRQ = 0;

  // ----------------------------------------
  // Values and timing
  // ----------------------------------------
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam int PRESCALE_DIV = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);
  localparam logic [3:0] PRESCALE_STEP = 4'h1;
  localparam logic [3:0] PRESCALE_ZERO = 4'h0;

  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'b00,
    MODE_RELOAD = 2'b01,
    MODE_BAUD = 2'b10,
    MODE_CLKOUT = 2'b11
  } mode_type;

endpackage

// ==== timer_two.sv ====
// 16-bit timer with capture, auto-reload, baud-rate and clock-out modes.
// Assumes pins asynchronous to CLOCK, a one-cycle strobe register port, CE as global enable.
`timescale 1ns/1ps
`default_nettype none

// Function
// R1 - Mode comes from counter, clock-out, capture and baud select bits.
// R2 - Run bit low stops counting; trigger pin channel stays active.
// R3 - Capture mode, trigger disabled: plain 16-bit timer setting overflow flag.
// R4 - Capture mode, trigger enabled: falling edge copies count to reload, sets event flag.
// R5 - Down-count enable resets to 0; set, trigger pin picks direction; the code does this in reload mode only.
// R6 - Reload mode: count up to FFFF, set overflow flag, load reload pair.
// R7 - Reload mode with trigger: overflow or falling edge reloads; edge sets event flag.
// R8 - Down counting enabled: direction from pin, trigger enable ignored; the code does this in reload mode only.
// R9 - Up/down mode, pin high: count up, overflow sets flag and reloads.
// R10 - Up/down mode, pin low: count down; equal to reload sets flag, loads FFFF.
// R11 - Up/down mode: event flag is 17th result bit, never an interrupt.
// R12 - Transmit and/or receive baud select make this timer that baud source.
// R13 - Baud mode: overflow reloads count, no interrupt.
// R14 - Baud mode: trigger edge sets event flag without reloading.
// R15 - Software keeps reload pair above 0x0010 for baud use.
// R16 - Clock-out: 50% clock at timer clock over (65536-reload)*4, no interrupt.
// R17 - Timer clock is system clock over 12, or undivided when bypassed.
// R18 - Both flags raise the same timer interrupt request.
// R19 - Software may set flags; only software write or reset clears them; in up/down mode the code's overflow also toggles the event flag.
// R20 - Interrupt when global enable, timer enable and a flag are all set.
// R21 - Software avoids writing count or reload during baud traffic.
// R22 - Overflow flag set by hardware only with both baud selects clear.
// R23 - Counter select 0 times system clock; 1 counts count-pin events.
// R24 - Count and trigger pins synchronised before falling edge detection.
module timer_two
  import timer_two_pkg::*;
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic [ADDR_WIDTH-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic TRIGGER_PIN,
  input wire logic COUNT_PIN_IN,
  output logic COUNT_PIN_OUT,
  output logic COUNT_PIN_OE_N,
  output logic BAUD_TX_TICK,
  output logic BAUD_RX_TICK,
  output logic IRQ
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
    logic rx_baud_select;
    logic tx_baud_select;
    logic ext_trigger_enable;
    logic run_control;
    logic counter_select;
    logic capture_reload_select;
    logic clock_out_enable;
    logic down_count_enable;
    logic prescale_bypass;
    logic global_irq_enable;
    logic timer_irq_enable;
    logic [15:0] count;
    logic [15:0] reload;
    logic [3:0] presc;
    logic trig_s1;
    logic trig_s2;
    logic trig_prev;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic pin_out;
    logic pin_oe_n;
    logic half;
    logic tx_tick;
    logic rx_tick;
    logic irq;
    logic [7:0] rdata;
  } state_type;

  localparam state_type RESET_STATE = '{pin_oe_n: 1'b1, default: '0};

  state_type st;
  state_type next_st;
  mode_type mode;
  logic updown;
  logic tick;
  logic inc;
  logic trig_fall;
  logic pin_fall;
  logic edge_act;
  logic ovf;
  logic ovf_set;
  logic ext_toggle;
  logic wr_control;
  logic [15:0] next_count;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic falling(input logic prev, input logic now);
    falling = prev & ~now;
  endfunction

  function automatic mode_type decode_mode(input state_type s);
    if (!s.counter_select && s.clock_out_enable) begin
      decode_mode = MODE_CLKOUT;
    end else if (s.tx_baud_select || s.rx_baud_select) begin
      decode_mode = MODE_BAUD;
    end else if (s.capture_reload_select) begin
      decode_mode = MODE_CAPTURE;
    end else begin
      decode_mode = MODE_RELOAD;
    end
  endfunction

  function automatic logic is_updown(input state_type s);
    is_updown = s.down_count_enable && (decode_mode(s) == MODE_RELOAD);
  endfunction

  function automatic logic [7:0] read_reg(input state_type s, input logic [ADDR_WIDTH-1:0] a);
    read_reg = BYTE_ZERO;
    unique case (a)
      REG_CONTROL: begin
        read_reg[BIT_OVERFLOW] = s.overflow_flag;
        read_reg[BIT_EXT_EVENT] = s.external_event_flag;
        read_reg[BIT_RX_BAUD] = s.rx_baud_select;
        read_reg[BIT_TX_BAUD] = s.tx_baud_select;
        read_reg[BIT_EXT_ENABLE] = s.ext_trigger_enable;
        read_reg[BIT_RUN] = s.run_control;
        read_reg[BIT_COUNTER_SEL] = s.counter_select;
        read_reg[BIT_CAPTURE_SEL] = s.capture_reload_select;
      end
      REG_MODE: begin
        read_reg[BIT_CLOCK_OUT] = s.clock_out_enable;
        read_reg[BIT_DOWN_COUNT] = s.down_count_enable;
      end
      REG_PRESCALE: read_reg[BIT_PRESCALE_BYPASS] = s.prescale_bypass;
      REG_IRQ_ENABLE: begin
        read_reg[BIT_GLOBAL_IRQ] = s.global_irq_enable;
        read_reg[BIT_TIMER_IRQ] = s.timer_irq_enable;
      end
      REG_COUNT_LOW: read_reg = s.count[7:0];
      REG_COUNT_HIGH: read_reg = s.count[15:8];
      REG_RELOAD_LOW: read_reg = s.reload[7:0];
      REG_RELOAD_HIGH: read_reg = s.reload[15:8];
    endcase
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    mode = decode_mode(st); // R1
    updown = is_updown(st); // R5
    wr_control = WR && (ADDR == REG_CONTROL);

    // Synchronisers and edge detect
    next_st.trig_s1 = TRIGGER_PIN; // R24
    next_st.trig_s2 = st.trig_s1;
    next_st.trig_prev = st.trig_s2;
    next_st.pin_s1 = COUNT_PIN_IN; // R24
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_prev = st.pin_s2;
    trig_fall = falling(st.trig_prev, st.trig_s2);
    pin_fall = falling(st.pin_prev, st.pin_s2);

    // Prescaler and count source
    tick = st.prescale_bypass || (st.presc == PRESCALE_LAST); // R17
    next_st.presc = (st.presc == PRESCALE_LAST) ? PRESCALE_ZERO : 4'(st.presc + PRESCALE_STEP); // R17
    inc = st.run_control && (st.counter_select ? pin_fall : tick); // R2 R23

    // Counting
    ovf = 1'b0;
    next_count = st.count;
    if (inc) begin
      if (updown && !st.trig_s2) begin
        if (st.count == st.reload) begin
          ovf = 1'b1; // R10
          next_count = COUNT_MAX; // R10
        end else begin
          next_count = 16'(st.count - COUNT_STEP); // R10
        end
      end else if (st.count == COUNT_MAX) begin
        ovf = 1'b1; // R3 R6 R9
        next_count = (mode == MODE_CAPTURE) ? COUNT_ZERO : st.reload; // R6 R9 R13
      end else begin
        next_count = 16'(st.count + COUNT_STEP);
      end
    end

    // Trigger edge, live even while stopped
    edge_act = trig_fall && st.ext_trigger_enable && !updown; // R2 R8
    if (edge_act && (mode == MODE_CAPTURE)) begin
      next_st.reload = st.count; // R4
    end
    if (edge_act && (mode == MODE_RELOAD)) begin
      next_count = st.reload; // R7
    end
    next_st.count = next_count;

    // Flags, hardware set wins over software clear
    ovf_set = ovf && ((mode == MODE_CAPTURE) || (mode == MODE_RELOAD)); // R13 R16 R22
    ext_toggle = ovf && updown; // R11
    next_st.overflow_flag = (wr_control ? WDATA[BIT_OVERFLOW] : st.overflow_flag) | ovf_set; // R19
    next_st.external_event_flag = ((wr_control ? WDATA[BIT_EXT_EVENT] : st.external_event_flag)
                                   | edge_act) ^ ext_toggle; // R4 R14 R19

    // Baud ticks
    next_st.tx_tick = ovf && st.tx_baud_select; // R12
    next_st.rx_tick = ovf && st.rx_baud_select; // R12

    // Clock output, toggles every second overflow
    next_st.pin_oe_n = (mode != MODE_CLKOUT); // R16 R23
    if (mode != MODE_CLKOUT) begin
      next_st.pin_out = 1'b0;
      next_st.half = 1'b0;
    end else if (ovf) begin
      next_st.half = ~st.half; // R16
      if (st.half) begin
        next_st.pin_out = ~st.pin_out; // R16
      end
    end

    // Register writes
    if (WR) begin
      unique case (ADDR)
        REG_CONTROL: begin
          next_st.rx_baud_select = WDATA[BIT_RX_BAUD];
          next_st.tx_baud_select = WDATA[BIT_TX_BAUD];
          next_st.ext_trigger_enable = WDATA[BIT_EXT_ENABLE];
          next_st.run_control = WDATA[BIT_RUN];
          next_st.counter_select = WDATA[BIT_COUNTER_SEL];
          next_st.capture_reload_select = WDATA[BIT_CAPTURE_SEL];
        end
        REG_MODE: begin
          next_st.clock_out_enable = WDATA[BIT_CLOCK_OUT];
          next_st.down_count_enable = WDATA[BIT_DOWN_COUNT];
        end
        REG_PRESCALE: next_st.prescale_bypass = WDATA[BIT_PRESCALE_BYPASS];
        REG_IRQ_ENABLE: begin
          next_st.global_irq_enable = WDATA[BIT_GLOBAL_IRQ];
          next_st.timer_irq_enable = WDATA[BIT_TIMER_IRQ];
        end
        REG_COUNT_LOW: next_st.count[7:0] = WDATA;
        REG_COUNT_HIGH: next_st.count[15:8] = WDATA;
        REG_RELOAD_LOW: next_st.reload[7:0] = WDATA;
        REG_RELOAD_HIGH: next_st.reload[15:8] = WDATA;
      endcase
    end

    // Shared interrupt request
    next_st.irq = next_st.global_irq_enable && next_st.timer_irq_enable
                  && (next_st.overflow_flag || (next_st.external_event_flag && !is_updown(next_st))); // R11 R18 R20

    // Read data for one cycle
    next_st.rdata = RD ? read_reg(st, ADDR) : BYTE_ZERO;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= RESET_STATE; // R5
    end else if (CE) begin
      st <= next_st;
    end
  end

  assign RDATA = st.rdata;
  assign COUNT_PIN_OUT = st.pin_out;
  assign COUNT_PIN_OE_N = st.pin_oe_n;
  assign BAUD_TX_TICK = st.tx_tick;
  assign BAUD_RX_TICK = st.rx_tick;
  assign IRQ = st.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  stop_hold_a: // R2
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (!st.run_control && !WR && !edge_act) |=> (st.count == $past(st.count)))
    else $error("Count moved while stopped");

  overflow_set_a: // R6
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (CE && ovf && (mode == MODE_RELOAD) && !updown && !WR) |=> (st.overflow_flag && st.count == $past(st.reload)))
    else $error("Reload overflow missed flag or reload");

  capture_copy_a: // R4
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (CE && edge_act && (mode == MODE_CAPTURE) && !WR) |=> (st.reload == $past(st.count) && st.external_event_flag))
    else $error("Capture did not copy count");

  edge_reload_a: // R7
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (CE && edge_act && (mode == MODE_RELOAD) && !WR) |=> (st.count == $past(st.reload)))
    else $error("Trigger edge did not reload");

  down_wrap_a: // R10
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (CE && inc && updown && !st.trig_s2 && (st.count == st.reload) && !WR) |=> (st.count == COUNT_MAX))
    else $error("Down count match did not load max");

  baud_no_flag_a: // R22
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      ((mode == MODE_BAUD) && !st.overflow_flag && !WR) |=> !st.overflow_flag)
    else $error("Overflow flag set in baud mode");

  flag_hold_a: // R19
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (st.overflow_flag && !wr_control) |=> st.overflow_flag)
    else $error("Overflow flag cleared without write");

  irq_level_a: // R20
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      IRQ == (st.global_irq_enable && st.timer_irq_enable
              && (st.overflow_flag || (st.external_event_flag && !is_updown(st)))))
    else $error("Interrupt level mismatch");

  prescale_a: // R17
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (CE && !st.prescale_bypass && !st.counter_select && st.run_control && (st.presc != PRESCALE_LAST)
       && !WR && !edge_act) |=> (st.count == $past(st.count)))
    else $error("Count advanced between prescale ticks");

  clock_drive_a: // R16
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (CE && !WR) |=> (COUNT_PIN_OE_N == ($past(mode) != MODE_CLKOUT)))
    else $error("Count pin drive mismatch");

  capture_wrap_a: // R3
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (CE && inc && (mode == MODE_CAPTURE) && (st.count == COUNT_MAX) && !WR)
      |=> (st.count == COUNT_ZERO && st.overflow_flag))
    else $error("Capture overflow did not wrap");

  updown_toggle_a: // R11
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (CE && ovf && updown && !WR) |=> (st.external_event_flag != $past(st.external_event_flag)))
    else $error("Up/down overflow did not toggle event bit");

  baud_no_reload_a: // R14
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (CE && edge_act && (mode == MODE_BAUD) && !ovf && !WR)
      |=> (st.external_event_flag && (16'(st.count - $past(st.count)) <= COUNT_STEP)))
    else $error("Baud trigger edge reloaded or missed flag");

  baud_tick_a: // R12
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (CE && ovf && st.tx_baud_select) |=> BAUD_TX_TICK)
    else $error("Transmit tick missing after overflow");

  clkout_no_flag_a: // R16
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      ((mode == MODE_CLKOUT) && !st.overflow_flag && !WR) |=> !st.overflow_flag)
    else $error("Overflow flag set in clock-out mode");

  pin_count_a: // R24
    assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (CE && st.run_control && st.counter_select && pin_fall && (mode == MODE_RELOAD) && !updown
       && (st.count != COUNT_MAX) && !WR && !edge_act) |=> (st.count == 16'($past(st.count) + COUNT_STEP)))
    else $error("Count pin edge not counted");

endmodule // timer_two

`default_nettype wire

// ==== timer_two_far.sv ====
// Far-side model: trigger pin, count pin and serial port tick counter.
// Assumes requests arrive as one-cycle strobes on the rising CLOCK edge.
`timescale 1ns/1ps
`default_nettype none
module timer_two_far (
  input wire logic clock,
  input wire logic trig_level,
  input wire logic trig_fall,
  input wire logic cnt_fall,
  input wire logic tx_tick,
  input wire logic rx_tick,
  output logic trigger_pin,
  output logic count_pin,
  output logic [15:0] tx_seen,
  output logic [15:0] rx_seen
);
  logic [2:0] trig_low = 3'h0;
  logic [2:0] cnt_low = 3'h0;
  initial tx_seen = 16'h0000;
  initial rx_seen = 16'h0000;
  // ----------------------------------------
  // Pin pulses held low four cycles
  // ----------------------------------------
  always @(posedge clock) begin
    trig_low <= trig_fall ? 3'h4 : (trig_low != 3'h0 ? trig_low - 3'h1 : 3'h0);
    cnt_low <= cnt_fall ? 3'h4 : (cnt_low != 3'h0 ? cnt_low - 3'h1 : 3'h0);
  end
  assign trigger_pin = (trig_low == 3'h0) & trig_level;
  assign count_pin = (cnt_low == 3'h0);
  // ----------------------------------------
  // Serial port rate ticks
  // ----------------------------------------
  always @(posedge clock) begin
    tx_seen <= tx_seen + {15'h0000, tx_tick};
    rx_seen <= rx_seen + {15'h0000, rx_tick};
  end
endmodule // timer_two_far
`default_nettype wire

// ==== timer_two_tb.sv ====
// Testbench for the reload/capture timer.
// Assumes the far-side model and a 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module timer_two_tb;
  import timer_two_pkg::*;
  logic CLOCK = 1'b0;
  logic ARST_N = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] RDATA;
  logic TRIGGER_PIN, COUNT_PIN_IN, COUNT_PIN_OUT, COUNT_PIN_OE_N;
  logic BAUD_TX_TICK, BAUD_RX_TICK, IRQ;
  logic trig_level = 1'b1;
  logic trig_fall = 1'b0;
  logic cnt_fall = 1'b0;
  logic [15:0] tx_seen, rx_seen, tx0, rx0;
  int err_count = 0;
  int num_checks = 0;
  always #10 CLOCK = ~CLOCK;
  timer_two timer_two_i (.CLOCK(CLOCK), .ARST_N(ARST_N), .CE(1'b1), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .TRIGGER_PIN(TRIGGER_PIN), .COUNT_PIN_IN(COUNT_PIN_IN),
    .COUNT_PIN_OUT(COUNT_PIN_OUT), .COUNT_PIN_OE_N(COUNT_PIN_OE_N), .BAUD_TX_TICK(BAUD_TX_TICK),
    .BAUD_RX_TICK(BAUD_RX_TICK), .IRQ(IRQ));
  timer_two_far timer_two_far_i (.clock(CLOCK), .trig_level(trig_level), .trig_fall(trig_fall),
    .cnt_fall(cnt_fall), .tx_tick(BAUD_TX_TICK), .rx_tick(BAUD_RX_TICK), .trigger_pin(TRIGGER_PIN),
    .count_pin(COUNT_PIN_IN), .tx_seen(tx_seen), .rx_seen(rx_seen));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= 3'(a);
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rd(input int a, input logic [7:0] exp);
    @(posedge CLOCK);
    ADDR <= 3'(a);
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1;
    chk({8'h00, RDATA}, {8'h00, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic pulse(input logic trig);
    @(posedge CLOCK);
    if (trig) trig_fall <= 1'b1;
    else cnt_fall <= 1'b1;
    @(posedge CLOCK);
    trig_fall <= 1'b0;
    cnt_fall <= 1'b0;
    cyc(10);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (IRQ !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk({15'h0000, IRQ}, 16'h0001);
  endtask
  task automatic half(input int exp);
    logic v;
    int n;
    v = COUNT_PIN_OUT;
    n = 0;
    while (COUNT_PIN_OUT === v && n < 400) begin
      cyc(1);
      n++;
    end
    v = COUNT_PIN_OUT;
    n = 0;
    while (COUNT_PIN_OUT === v && n < 400) begin
      cyc(1);
      n++;
    end
    chk(16'(n), 16'(exp));
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    stop_test();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge CLOCK);
    ARST_N <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a, 8'h00);
    chk({14'h0000, COUNT_PIN_OE_N, IRQ}, 16'h0002);
    $display("reset test done");
    wr(6, 8'hF0); wr(7, 8'hFF); wr(4, 8'hF0); wr(5, 8'hFF);
    wr(2, 8'h01); wr(3, 8'h03); wr(0, 8'h04);
    wait_irq();
    rd(0, 8'h84);
    rd(5, 8'hFF);
    cyc(40);
    rd(0, 8'h84);
    wr(0, 8'h80);
    wr(0, 8'h00);
    cyc(3);
    chk({15'h0000, IRQ}, 16'h0000);
    wr(0, 8'h80);
    cyc(3);
    chk({15'h0000, IRQ}, 16'h0001);
    wr(3, 8'h01);
    cyc(3);
    chk({15'h0000, IRQ}, 16'h0000);
    wr(3, 8'h03); wr(0, 8'h00);
    wr(4, 8'h34); wr(0, 8'h08);
    pulse(1'b1);
    rd(4, 8'hF0);
    rd(0, 8'h48);
    wr(0, 8'h00);
    $display("reload test done");
    wr(0, 8'h01); wr(4, 8'h34); wr(5, 8'h12);
    pulse(1'b1);
    rd(6, 8'hF0);
    rd(0, 8'h01);
    wr(0, 8'h09);
    pulse(1'b1);
    rd(6, 8'h34);
    rd(7, 8'h12);
    rd(0, 8'h49);
    chk({15'h0000, IRQ}, 16'h0001);
    wr(0, 8'h00);
    wr(4, 8'hF0); wr(5, 8'hFF); wr(0, 8'h05);
    wait_irq();
    rd(5, 8'h00);
    rd(0, 8'h85);
    wr(0, 8'h00);
    $display("capture test done");
    trig_level <= 1'b0;
    wr(1, 8'h01); wr(6, 8'h00); wr(7, 8'h01); wr(4, 8'h08); wr(5, 8'h01); wr(0, 8'h04);
    wait_irq();
    rd(0, 8'hC4);
    wr(0, 8'h44);
    cyc(3);
    chk({15'h0000, IRQ}, 16'h0000);
    rd(5, 8'hFF);
    wr(0, 8'h00); wr(1, 8'h00);
    trig_level <= 1'b1;
    $display("up down test done");
    for (int i = 0; i < 2; i++) begin
      wr(6, 8'hF0); wr(7, 8'hFF); wr(4, 8'hF0); wr(5, 8'hFF);
      tx0 = tx_seen;
      rx0 = rx_seen;
      wr(0, 8'h04 | (8'h10 << i));
      cyc(100);
      chk(16'(tx_seen - tx0 >= 6), 16'(i == 0));
      chk(16'(rx_seen - rx0 >= 6), 16'(i == 1));
      chk({15'h0000, IRQ}, 16'h0000);
      rd(0, 8'h04 | (8'h10 << i));
      wr(0, 8'h0C | (8'h10 << i));
      pulse(1'b1);
      rd(0, 8'h4C | (8'h10 << i));
      chk({15'h0000, IRQ}, 16'h0001);
      wr(0, 8'h00);
    end
    $display("baud test done");
    wr(1, 8'h02); wr(6, 8'hFC); wr(7, 8'hFF); wr(0, 8'h04);
    cyc(20);
    chk({15'h0000, COUNT_PIN_OE_N}, 16'h0000);
    half(8);
    chk({15'h0000, IRQ}, 16'h0000);
    wr(2, 8'h00);
    half(96);
    wr(1, 8'h00); wr(0, 8'h00);
    cyc(3);
    chk({15'h0000, COUNT_PIN_OE_N}, 16'h0001);
    $display("clock out test done");
    wr(2, 8'h01); wr(4, 8'h00); wr(5, 8'h00); wr(0, 8'h06);
    repeat (3) pulse(1'b0);
    rd(4, 8'h03);
    $display("counter test done");
    stop_test();
  end
endmodule // timer_two_tb
`default_nettype wire
